// file: hdl/model_readable_field_params.svh
// Offsets, field positions, reset values and access modes for the register fields
`ifndef MODEL_READABLE_FIELD_PARAMS_SVH
`define MODEL_READABLE_FIELD_PARAMS_SVH
// Access modes as seen from the processor
`define MODE_READ        2'h0
`define MODE_WRITE       2'h1
`define MODE_READWRITE   2'h2
`define MODE_CONSTANT    2'h3
// Word offsets (byte address = 4 * offset)
`define FIELD_OFFSET     4'h0
`define BIT_OFFSET       4'h0
`define OUT_OFFSET       4'h1
`define MEM_BASE         4'h8
// Bit ranges within a word
`define FIELD_MSB        15
`define FIELD_LSB        0
`define BIT_POS          16
`define OUT_MSB          7
`define OUT_LSB          0
// Reset values and memory depth
`define FIELD_INIT       16'h0000
`define BIT_INIT         1'h0
`define MEM_DEPTH        8
`endif

// file: hdl/model_readable_field_pkg.sv
// Types for the register field block
package model_readable_field_pkg;
   typedef logic [1:0] mode_t;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ACCESS = 2'b01
   } bus_state_e;
endpackage : model_readable_field_pkg

// file: hdl/memory_mapped_register_fields.sv
// Processor-mapped register fields and dual-access memory behind APB
`timescale 1ns/1ps
`include "model_readable_field_params.svh"
`default_nettype none

module memory_mapped_register_fields
   import model_readable_field_pkg::*;
#(
   parameter int          FieldMsb   = `FIELD_MSB,
   parameter int          FieldLsb   = `FIELD_LSB,
   parameter bit          FieldSigned = 1'b0,
   parameter mode_t       FieldMode  = `MODE_READWRITE,
   parameter int          BitPos     = `BIT_POS,
   parameter mode_t       BitMode    = `MODE_READWRITE,
   parameter int          OutMsb     = `OUT_MSB,
   parameter int          OutLsb     = `OUT_LSB,
   parameter int          MemDepth   = `MEM_DEPTH,
   parameter mode_t       MemMode    = `MODE_READWRITE,
   parameter bit          MemPreload = 1'b1,
   parameter logic [31:0] MemInit [MemDepth] = '{default: 32'h0000_0000}
) (
   // Clock and reset
   input  wire logic                             clk,
   input  wire logic                             reset,
   // APB slave
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [11:0]                      paddr,
   input  wire logic [31:0]                      pwdata,
   input  wire logic [3:0]                       pstrb,
   output logic                                  pready,
   output logic [31:0]                           prdata,
   output logic                                  pslverr,
   // Datapath side: model-readable field and single bit
   output logic [FieldMsb-FieldLsb:0]            fieldValue,
   output logic                                  bitValue,
   // Datapath side: model-written field
   input  wire logic [OutMsb-OutLsb:0]           outData,
   input  wire logic                             outWrite,
   // Datapath side: dual access memory
   input  wire logic [$clog2(MemDepth)-1:0]      memAddr,
   input  wire logic                             memWrite,
   input  wire logic [31:0]                      memWdata,
   output logic [31:0]                           memRdata
);

   localparam int FW = FieldMsb - FieldLsb + 1;
   localparam int OW = OutMsb - OutLsb + 1;
   localparam int AW = $clog2(MemDepth);

   // ---------------------------------------------------------------
   // Configuration checks
   // ---------------------------------------------------------------
   // disjoint ranges at one offset
   initial begin
      if (`FIELD_OFFSET == `BIT_OFFSET && BitPos >= FieldLsb && BitPos <= FieldMsb) begin
         $error("bit register overlaps field register");
      end
      if (`FIELD_OFFSET == `OUT_OFFSET && !(OutLsb > FieldMsb || OutMsb < FieldLsb)) begin
         $error("output field overlaps field register");
      end
      if (`BIT_OFFSET == `OUT_OFFSET && BitPos >= OutLsb && BitPos <= OutMsb) begin
         $error("bit register overlaps output field");
      end
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [FW-1:0]       field;
      logic                bitq;
      logic [OW-1:0]       out;
      logic [31:0]         rdata;
      logic [31:0]         dpRdata;
      logic [MemDepth-1:0][31:0] mem;
      bus_state_e          busSt;
   } state_s;

   state_s stateReg;
   state_s stateNext;

   logic       busAccess;
   logic       busWrite;
   logic       busRead;
   logic [9:0] wordIdx;
   logic       hitWord0;
   logic       hitWord1;
   logic       hitBitWord;
   logic       hitMem;
   logic [AW-1:0] memIdx;
   logic [31:0] strbMask;

   assign busAccess = psel && penable;
   assign busWrite  = busAccess && pwrite;
   assign busRead   = busAccess && !pwrite;
   assign wordIdx    = paddr[11:2];
   assign hitWord0   = wordIdx == 10'(`FIELD_OFFSET);
   assign hitBitWord = wordIdx == 10'(`BIT_OFFSET);
   assign hitWord1   = wordIdx == 10'(`OUT_OFFSET);
   assign hitMem     = wordIdx >= 10'(`MEM_BASE) && wordIdx < 10'(`MEM_BASE + MemDepth);
   assign memIdx     = AW'(wordIdx - 10'(`MEM_BASE));

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_strb
         assign strbMask[gi*8 +: 8] = {8{pstrb[gi]}};
      end
   endgenerate

   // Writes finish at once; a read waits one cycle so prdata comes from a flop
   // read wait state
   assign pready  = !busRead || stateReg.busSt == ST_ACCESS;
   assign pslverr = busAccess && !(hitWord0 || hitBitWord || hitWord1 || hitMem);

   always_comb begin
      logic [31:0] wordVal;
      logic [31:0] newWord;
      wordVal   = 32'h0000_0000;
      newWord   = 32'h0000_0000;
      stateNext = stateReg;

      if (hitWord0 && (FieldMode == `MODE_READWRITE || FieldMode == `MODE_READ)) begin
         wordVal[FieldMsb:FieldLsb] = stateReg.field;
      end
      if (hitBitWord && (BitMode == `MODE_READWRITE || BitMode == `MODE_READ)) begin
         wordVal[BitPos] = stateReg.bitq;
      end
      if (hitWord1) begin
         wordVal[OutMsb:OutLsb] = stateReg.out;
      end
      if (hitMem && MemMode != `MODE_WRITE && MemMode != `MODE_CONSTANT) begin
         wordVal = stateReg.mem[memIdx];
      end
      if (busRead) begin
         stateNext.rdata = wordVal;
      end
      case (stateReg.busSt)
         ST_IDLE: begin
            if (busRead) begin
               stateNext.busSt = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            stateNext.busSt = ST_IDLE;
         end
         default: begin
            stateNext.busSt = ST_IDLE;
         end
      endcase

      if (busWrite) begin
         newWord = pwdata & strbMask;
         if (hitWord0 && (FieldMode == `MODE_WRITE || FieldMode == `MODE_READWRITE)) begin
            stateNext.field = (stateReg.field & ~FW'(strbMask >> FieldLsb))
                            | FW'(newWord >> FieldLsb);
         end
         if (hitBitWord && (BitMode == `MODE_WRITE || BitMode == `MODE_READWRITE)
             && pstrb[BitPos/8]) begin
            stateNext.bitq = pwdata[BitPos];
         end
         if (hitMem && (MemMode == `MODE_WRITE || MemMode == `MODE_READWRITE)) begin
            stateNext.mem[memIdx] = (stateReg.mem[memIdx] & ~strbMask) | newWord;
         end
      end

      if (outWrite) begin
         stateNext.out = outData;
      end

      // datapath access, after bus so datapath wins a collision
      if (memWrite) begin
         stateNext.mem[memAddr] = memWdata;
      end
      stateNext.dpRdata = stateReg.mem[memAddr];

      if (reset) begin
         stateNext.field   = FW'(`FIELD_INIT);
         stateNext.bitq    = `BIT_INIT;
         stateNext.out     = '0;
         stateNext.rdata   = 32'h0000_0000;
         stateNext.dpRdata = 32'h0000_0000;
         stateNext.busSt   = ST_IDLE;
         if (MemPreload) begin
            for (int i = 0; i < MemDepth; i++) begin
               stateNext.mem[i] = MemInit[i];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      stateReg <= stateNext;
   end

   assign fieldValue = stateReg.field;
   assign bitValue   = stateReg.bitq;
   assign prdata     = stateReg.rdata;
   assign memRdata   = stateReg.dpRdata;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_rw_update;
      busWrite && hitWord0 && FieldMode == `MODE_READWRITE && pstrb == 4'hF
         |=> fieldValue == $past(pwdata[FieldMsb:FieldLsb]);
   endproperty
   a_rw_update: assert property (p_rw_update) else $error("field not updated");

   property p_const_hold;
      FieldMode == `MODE_CONSTANT |=> $stable(fieldValue);
   endproperty
   a_const_hold: assert property (p_const_hold) else $error("constant field changed");

   property p_wo_read;
      busRead && hitWord0 && FieldMode == `MODE_WRITE |=> prdata[FieldMsb:FieldLsb] == '0;
   endproperty
   a_wo_read: assert property (p_wo_read) else $error("write-only field read back");

   property p_out_cap;
      outWrite |=> stateReg.out == $past(outData);
   endproperty
   a_out_cap: assert property (p_out_cap) else $error("output field missed write");

   property p_out_hold;
      !outWrite |=> $stable(stateReg.out);
   endproperty
   a_out_hold: assert property (p_out_hold) else $error("output field changed");

   property p_out_read;
      busRead && hitWord1 && !outWrite ##1 !outWrite
         |-> prdata[OutMsb:OutLsb] == stateReg.out;
   endproperty
   a_out_read: assert property (p_out_read) else $error("output field misread");

   property p_mem_dp;
      memWrite ##1 !memWrite && !(busWrite && hitMem) && memAddr == $past(memAddr)
         |=> memRdata == $past(memWdata, 2);
   endproperty
   a_mem_dp: assert property (p_mem_dp) else $error("memory datapath mismatch");

   property p_field_drive;
      !(busWrite && hitWord0) |=> $stable(fieldValue);
   endproperty
   a_field_drive: assert property (p_field_drive) else $error("field not presented");

   property p_ready;
      busRead && !pready |=> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("read wait too long");

   property p_bit_ro;
      BitMode == `MODE_READ || BitMode == `MODE_CONSTANT |=> $stable(bitValue);
   endproperty
   a_bit_ro: assert property (p_bit_ro) else $error("read-only bit changed");

   property p_mem_range;
      busAccess && wordIdx >= 10'(`MEM_BASE + MemDepth) |-> pslverr;
   endproperty
   a_mem_range: assert property (p_mem_range) else $error("access beyond memory");

   c_field_write: cover property (busWrite && hitWord0);
   c_out_read:    cover property (busRead && hitWord1);
   c_mem_both:    cover property (busWrite && hitMem ##1 memWrite);
   c_read_wait:   cover property (busRead && !pready ##1 busRead && pready);

endmodule : memory_mapped_register_fields

`default_nettype wire

// file: bench/apb_master.sv
// APB master model standing in for the processor
`timescale 1ns/1ps
`default_nettype none

module apb_master (
   // Clock
   input  wire logic        clk,
   // Request
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   // Answer
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h00000000;
      pstrb   = 4'h0;
   end

   // -----------------------------
   // One transfer
   // -----------------------------
   // Reads take a wait state; pready is sampled at each edge until high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : apb_master
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking testbench for the register field block
`timescale 1ns/1ps
`include "model_readable_field_params.svh"
`default_nettype none

module tb_top;
   import model_readable_field_pkg::*;
   localparam logic [31:0] INIT [8] = '{32'h000000A0, 32'h000000A1, 32'h000000A2,
      32'h000000A3, 32'h000000A4, 32'h000000A5, 32'h000000A6, 32'h000000A7};
   logic        clk = 1'b0, reset = 1'b1, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, memWdata = 32'h0, memRdata, rdat;
   logic [3:0]  pstrb;
   logic [15:0] fieldValue;
   logic [7:0]  outData = 8'h00;
   logic [2:0]  memAddr = 3'h0;
   logic        bitValue, outWrite = 1'b0, memWrite = 1'b0, rerr;
   logic        altSel = 1'b0, pselMain, pselAlt, preadyMain, preadyAlt;
   logic        pslverrMain, pslverrAlt, bitAlt;
   logic [31:0] prdataMain, prdataAlt, memRdataAlt;
   logic [15:0] fieldAlt;
   int          n_mismatch = 0, n_tests = 0;

   always #5 clk = ~clk;

   memory_mapped_register_fields #(.MemInit(INIT)) dut_u (.clk(clk), .reset(reset),
      .psel(pselMain), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(preadyMain), .prdata(prdataMain), .pslverr(pslverrMain),
      .fieldValue(fieldValue), .bitValue(bitValue), .outData(outData),
      .outWrite(outWrite), .memAddr(memAddr), .memWrite(memWrite),
      .memWdata(memWdata), .memRdata(memRdata));
   // Second slave with the other access modes, selected by altSel
   memory_mapped_register_fields #(.FieldMode(`MODE_WRITE), .BitMode(`MODE_READ),
      .MemMode(`MODE_CONSTANT), .MemInit(INIT)) dut_alt_u (.clk(clk), .reset(reset),
      .psel(pselAlt), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(preadyAlt), .prdata(prdataAlt), .pslverr(pslverrAlt),
      .fieldValue(fieldAlt), .bitValue(bitAlt), .outData(outData),
      .outWrite(outWrite), .memAddr(memAddr), .memWrite(memWrite),
      .memWdata(memWdata), .memRdata(memRdataAlt));
   assign pselMain = psel && !altSel;
   assign pselAlt  = psel && altSel;
   assign pready   = altSel ? preadyAlt : preadyMain;
   assign prdata   = altSel ? prdataAlt : prdataMain;
   assign pslverr  = altSel ? pslverrAlt : pslverrMain;
   apb_master m_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr));

   // -----------------------------
   // Helpers
   // -----------------------------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex) begin
         $display("unexpected %s expected %h seen %h", nm, ex, got);
         n_mismatch++;
      end
   endtask : chk

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      m_u.xfer(w, a, d, s, rdat, rerr);
      // Registered outputs settle after the accept edge
      @(negedge clk);
   endtask : bus

   task automatic give_verdict();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   // -----------------------------
   // Scenarios
   // -----------------------------
   task automatic t_reset();
      chk("fieldValue", 32'h0, {16'h0, fieldValue});
      chk("bitValue", 32'h0, {31'h0, bitValue});
      bus(1'b0, 12'h000, 32'h0, 4'h0);
      chk("word0", 32'h0, rdat);
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 12'h020 + 12'(4 * i), 32'h0, 4'h0);
         chk("preload", INIT[i], rdat);
      end
      $display("t_reset done");
   endtask : t_reset

   task automatic t_field();
      bus(1'b1, 12'h000, 32'hFFFF5A3C, 4'hF);
      chk("fieldValue", 32'h5A3C, {16'h0, fieldValue});
      chk("bitValue", 32'h1, {31'h0, bitValue});
      bus(1'b0, 12'h000, 32'h0, 4'h0);
      chk("word0", 32'h00015A3C, rdat);
      // Low strobes only: the bit in byte 2 must keep its value
      bus(1'b1, 12'h000, 32'h00008001, 4'h3);
      chk("fieldValue", 32'h8001, {16'h0, fieldValue});
      chk("bitValue", 32'h1, {31'h0, bitValue});
      $display("t_field done");
   endtask : t_field

   task automatic t_out();
      @(posedge clk);
      outData  <= 8'hC5;
      outWrite <= 1'b1;
      @(posedge clk);
      outData  <= 8'h3A;
      outWrite <= 1'b0;
      bus(1'b0, 12'h004, 32'h0, 4'h0);
      chk("word1", 32'h000000C5, rdat);
      bus(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF);
      bus(1'b0, 12'h004, 32'h0, 4'h0);
      chk("word1", 32'h000000C5, rdat);
      $display("t_out done");
   endtask : t_out

   task automatic t_mem();
      bus(1'b1, 12'h028, 32'h12345678, 4'hF);
      @(posedge clk);
      memAddr <= 3'h2;
      @(posedge clk);
      @(negedge clk);
      chk("memRdata", 32'h12345678, memRdata);
      @(posedge clk);
      memAddr  <= 3'h5;
      memWdata <= 32'hCAFE0005;
      memWrite <= 1'b1;
      @(posedge clk);
      memWrite <= 1'b0;
      bus(1'b0, 12'h034, 32'h0, 4'h0);
      chk("word13", 32'hCAFE0005, rdat);
      bus(1'b1, 12'h040, 32'h0, 4'hF);
      chk("pslverr", 32'h1, {31'h0, rerr});
      $display("t_mem done");
   endtask : t_mem

   task automatic t_modes();
      @(posedge clk);
      altSel <= 1'b1;
      bus(1'b1, 12'h000, 32'hFFFF1234, 4'hF);
      chk("altField", 32'h1234, {16'h0, fieldAlt});
      chk("altBit", 32'h0, {31'h0, bitAlt});
      bus(1'b0, 12'h000, 32'h0, 4'h0);
      chk("altWord0", 32'h0, rdat);
      bus(1'b1, 12'h020, 32'hFFFFFFFF, 4'hF);
      bus(1'b0, 12'h020, 32'h0, 4'h0);
      chk("altMemRead", 32'h0, rdat);
      chk("altPslverr", 32'h0, {31'h0, rerr});
      @(posedge clk);
      memAddr <= 3'h0;
      @(posedge clk);
      @(negedge clk);
      chk("altMemRdata", INIT[0], memRdataAlt);
      @(posedge clk);
      altSel <= 1'b0;
      $display("t_modes done");
   endtask : t_modes

   task automatic t_rerun();
      bus(1'b1, 12'h000, 32'h0001FFFF, 4'hF);
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk("fieldValue", 32'h0, {16'h0, fieldValue});
      chk("bitValue", 32'h0, {31'h0, bitValue});
      bus(1'b0, 12'h028, 32'h0, 4'h0);
      chk("preload", INIT[2], rdat);
      bus(1'b0, 12'h004, 32'h0, 4'h0);
      chk("word1", 32'h0, rdat);
      $display("t_rerun done");
   endtask : t_rerun

   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_field();
      t_out();
      t_mem();
      t_modes();
      t_rerun();
      give_verdict();
   end

   // Watchdog well beyond the hundred or so cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
